/* lbt_bp_map.sv */
// Purpose: Backplane activity pattern for a drive mode and active row.
// Assumes: row_i never exceeds the last row of the mode.
// Notes:   Duplicated outputs may be tied together on the board.
module lbt_bp_map
    import lbt_pkg::*;
(
    input  lbt_mode_t   mode_i,
    input  wire logic [1:0] row_i,
    output logic [3:0]  bp_o
);
    logic [3:0] onehot;

    assign onehot = 4'h1 << row_i;

    always_comb begin
        case (mode_i)
            LBT_STATIC: bp_o = 4'hF;
            LBT_MUX2:   bp_o = {onehot[1:0], onehot[1:0]};
            LBT_MUX3:   bp_o = {onehot[1], onehot[2:0]};
            default:    bp_o = onehot;
        endcase
    end
endmodule // lbt_bp_map

/* lbt_far_end.sv */
// Purpose: Far-side model: external clock source and a cascaded peer on the sync wire.
// Assumes: Bench clock drives it; outputs change just after rising edges.
// Notes:   The clock stands still while not selected; the pin is then driven by the block.
module lbt_far_end (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       run_i,
    input  wire logic [7:0] half_i,
    input  wire logic       pull_i,
    output logic            ext_clk_o,
    output logic            sync_pull_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt_q;

    // ==========================================================
    // Clock source: keeps toggling for as long as it is selected
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q     <= 8'h00;
            ext_clk_o <= 1'b0;
        end else if (run_i) begin
            if (cnt_q >= half_i - 8'h01) begin
                cnt_q     <= 8'h00;
                ext_clk_o <= !ext_clk_o;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // ==========================================================
    // Peer device pulls the open-drain sync wire low for one cycle
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_pull_o <= 1'b0;
        end else begin
            sync_pull_o <= pull_i;
        end
    end
endmodule // lbt_far_end

/* lbt_pkg.sv */
// Purpose: Shared types and constants for the LCD RAM and backplane timing block.
// Assumes: System clock of 40 MHz; drive mode comes from an outside command decoder.
// Notes:   All counts derive from the times and figures below.
package lbt_pkg;

    // ==========================================================
    // Drive modes
    typedef enum logic [1:0] {LBT_STATIC, LBT_MUX2, LBT_MUX3, LBT_MUX4} lbt_mode_t;

    // ==========================================================
    // Display RAM geometry
    localparam int unsigned LBT_COLS     = 40;
    localparam int unsigned LBT_ROWS     = 4;
    localparam logic [5:0]  LBT_COLS_W   = 6'h28;
    localparam logic [5:0]  LBT_STEP_S   = 6'h08;
    localparam logic [5:0]  LBT_STEP_2   = 6'h04;
    localparam logic [5:0]  LBT_STEP_3   = 6'h03;
    localparam logic [5:0]  LBT_STEP_4   = 6'h02;

    // ==========================================================
    // Frame timing: frame rate is the selected clock divided by 24
    localparam int unsigned LBT_FRAME_DIV = 24;
    localparam logic [4:0]  LBT_FRAME_MAX = 5'(LBT_FRAME_DIV - 1);
    localparam logic [4:0]  LBT_SPLIT_2   = 5'h0C;
    localparam logic [4:0]  LBT_SPLIT_3A  = 5'h08;
    localparam logic [4:0]  LBT_SPLIT_3B  = 5'h10;
    localparam logic [4:0]  LBT_SPLIT_4A  = 5'h06;
    localparam logic [4:0]  LBT_SPLIT_4B  = 5'h0C;
    localparam logic [4:0]  LBT_SPLIT_4C  = 5'h12;

    // ==========================================================
    // Internal oscillator model: half period as a time, then in cycles
    localparam int unsigned LBT_SYS_PERIOD_NS = 25;
    localparam int unsigned LBT_OSC_HALF_NS   = 250;
    localparam int unsigned LBT_OSC_HALF_CYC  = (LBT_OSC_HALF_NS + LBT_SYS_PERIOD_NS - 1) / LBT_SYS_PERIOD_NS;
    localparam logic [7:0]  LBT_OSC_MAX       = 8'(LBT_OSC_HALF_CYC - 1);

    // ==========================================================
    // Byte-write path from the command decoder
    typedef struct packed {
        logic       load;
        logic [5:0] ptr;
        logic       store;
        logic [7:0] data;
    } lbt_wr_req_t;

endpackage

/* lbt_ram_backplane_timing_tb_top.sv */
// Purpose: Self-checking bench for display RAM packing, backplane drive and frame timing.
// Assumes: Inputs change at the falling clock edge; a shadow RAM predicts segment data.
// Notes:   The shadow drops columns past 39 and wraps its pointer modulo 40.
module lcd_ram_backplane_timing_tb_top;
    import lbt_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk;
    logic        resetn;
    logic        osc_sel;
    logic        pull;
    lbt_mode_t   drive_mode;
    lbt_wr_req_t wr_req;
    logic        clk_o, clk_oe_o, sync_o, sync_oe_o, frame_o, far_clk, far_pull;
    logic [3:0]  backplane_out_o;
    logic [39:0] segment_outputs_o;
    logic [39:0] sh [4];
    int          ptr_m, n_errors, comparisons, cyc;

    // ==========================================================
    // Shared pins: clock pin and open-drain sync wire with pull-up
    wire ext_clk = clk_oe_o ? clk_o : far_clk;
    wire sync_w  = !((sync_oe_o && !sync_o) || far_pull);

    lbt_top DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .oscillator_select_pin_i(osc_sel),
        .ext_clk_i(ext_clk), .clk_o(clk_o), .clk_oe_o(clk_oe_o), .sync_i(sync_w), .sync_o(sync_o),
        .sync_oe_o(sync_oe_o), .drive_mode_i(drive_mode), .wr_req_i(wr_req),
        .backplane_out_o(backplane_out_o), .segment_outputs_o(segment_outputs_o), .frame_o(frame_o));

    lbt_far_end far (.sys_clk_i(sys_clk), .resetn_i(resetn), .run_i(osc_sel), .half_i(8'h03),
        .pull_i(pull), .ext_clk_o(far_clk), .sync_pull_o(far_pull));

    always #12.5 sys_clk = ~sys_clk;

    // ==========================================================
    // Reporting
    task automatic give_verdict();
        $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [3:0] bp_pat(input int n, input int r);
        case (n)
            1: return 4'hF;
            2: return (r == 0) ? 4'h5 : 4'hA;
            3: return (r == 0) ? 4'h1 : ((r == 1) ? 4'hA : 4'h4);
            default: return 4'h1 << r;
        endcase
    endfunction

    task automatic set_mode(input int n);
        @(negedge sys_clk);
        drive_mode = lbt_mode_t'(n - 1);
        repeat (2) @(negedge sys_clk);
    endtask

    // One byte or one pointer load; released fields show inverted values
    task automatic wr(input logic ld, input logic [5:0] p, input logic [7:0] d);
        int n;
        n = int'(drive_mode) + 1;
        @(negedge sys_clk);
        wr_req = '{load: ld, ptr: p, store: !ld, data: d};
        @(negedge sys_clk);
        wr_req = '{load: 1'b0, ptr: ~p, store: 1'b0, data: ~d};
        if (ld) begin
            ptr_m = p;
        end else begin
            for (int j = 0; j < 8; j++) begin
                if (ptr_m + j / n < 40) sh[j % n][ptr_m + j / n] = d[7 - j];
            end
            ptr_m = (ptr_m + (8 + n - 1) / n) % 40;
        end
    endtask

    task automatic t_rows(input int n);
        int k;
        for (int r = 0; r < n; r++) begin
            k = 0;
            while (backplane_out_o !== bp_pat(n, r) && k < 1000) begin
                @(negedge sys_clk);
                k++;
            end
            repeat (2) @(negedge sys_clk);
            chk(40'(backplane_out_o), 40'(bp_pat(n, r)));
            chk(segment_outputs_o, sh[r]);
        end
    endtask

    task automatic frame_gap(output int k);
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (frame_o !== 1'b1 && k < 2000);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        @(negedge sys_clk);
        resetn = 1'b0;
        drive_mode = LBT_STATIC;
        sh = '{default: 40'h0};
        ptr_m = 0;
        repeat (3) @(negedge sys_clk);
        chk(segment_outputs_o, 40'h0);
        chk(40'({backplane_out_o, frame_o, clk_oe_o, sync_oe_o}), 40'h0);
        resetn = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(40'({clk_oe_o, sync_o}), 40'({!osc_sel, 1'b0}));
        chk(40'(backplane_out_o), 40'hF);
    endtask

    task automatic t_static();
        t_reset();
        wr(1'b1, 6'h00, 8'h00);
        wr(1'b0, 6'h00, 8'hA5);
        wr(1'b0, 6'h00, 8'h3C);
        wr(1'b1, 6'h24, 8'h00);
        wr(1'b0, 6'h00, 8'hFF);
        wr(1'b0, 6'h00, 8'h81);
        t_rows(1);
    endtask

    task automatic t_mux2();
        t_reset();
        set_mode(2);
        wr(1'b1, 6'h01, 8'h00);
        wr(1'b0, 6'h00, 8'h96);
        wr(1'b0, 6'h00, 8'h3C);
        t_rows(2);
    endtask

    // Ones laid down in four-row mode reveal the bits three-row mode must leave alone
    task automatic t_mux34();
        t_reset();
        set_mode(4);
        wr(1'b1, 6'h02, 8'h00);
        wr(1'b0, 6'h00, 8'hFF);
        wr(1'b0, 6'h00, 8'h5A);
        t_rows(4);
        set_mode(3);
        wr(1'b1, 6'h00, 8'h00);
        wr(1'b0, 6'h00, 8'h00);
        wr(1'b0, 6'h00, 8'h00);
        t_rows(3);
    endtask

    task automatic t_sync();
        int k;
        frame_gap(k);
        chk(40'({frame_o, sync_oe_o, sync_w}), 40'h6);
        repeat (240) @(negedge sys_clk);
        pull = 1'b1;
        @(negedge sys_clk);
        pull = 1'b0;
        frame_gap(k);
        chk(40'(k >= 455 && k <= 485), 40'h1);
    endtask

    task automatic t_clock();
        int   k;
        logic v;
        @(negedge sys_clk);
        v = clk_o;
        k = 0;
        while (clk_o === v && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        v = clk_o;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (clk_o === v && k < 100);
        chk(40'(k), 40'(LBT_OSC_HALF_CYC));
        frame_gap(k);
        frame_gap(k);
        chk(40'(k), 40'(2 * LBT_OSC_HALF_CYC * LBT_FRAME_DIV));
        osc_sel = 1'b1;
        repeat (3) frame_gap(k);
        chk(40'(clk_oe_o), 40'h0);
        chk(40'(k), 40'(6 * LBT_FRAME_DIV));
    endtask

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        osc_sel = 1'b0;
        pull = 1'b0;
        drive_mode = LBT_STATIC;
        wr_req = '0;
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        t_static();
        t_mux2();
        t_mux34();
        t_sync();
        t_clock();
        give_verdict();
    end
endmodule // lcd_ram_backplane_timing_tb_top

/* lbt_tick_div.sv */
// Purpose: Modulo counter that emits a one-cycle tick on wrap.
// Assumes: en is a one-cycle enable or held high; clr has priority over counting.
// Notes:   Used for the oscillator half period and the frame divider.
module lbt_tick_div #(
    parameter int unsigned W   = 8,
    parameter logic [W-1:0] MAX = '1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         en_i,
    input  wire logic         clr_i,
    output logic [W-1:0]      cnt_o,
    output logic              tick_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         wrap;

    assign wrap   = en_i && (cnt_q == MAX);
    assign cnt_d  = clr_i ? '0 : (wrap ? '0 : (en_i ? W'(cnt_q + 1'b1) : cnt_q));
    assign tick_o = wrap && !clr_i;
    assign cnt_o  = cnt_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // lbt_tick_div

/* lbt_top.sv */
// Purpose: Clock select, frame timing, display RAM and backplane/segment drive.
// Assumes: ext_clk_i and sync_i are synchronous to sys_clk_i; ext clock is slower.
// Notes:   Outputs are logic-level waveforms; analogue bias levels are outside.

module lbt_top
    import lbt_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        oscillator_select_pin_i,
    input  wire logic        ext_clk_i,
    output logic             clk_o,
    output logic             clk_oe_o,
    input  wire logic        sync_i,
    output logic             sync_o,
    output logic             sync_oe_o,
    input  lbt_mode_t        drive_mode_i,
    input  lbt_wr_req_t      wr_req_i,
    output logic [3:0]       backplane_out_o,
    output logic [39:0]      segment_outputs_o,
    output logic             frame_o
);
    // ==========================================================
    // Clock selection
    logic       osc_sel_q;
    lbt_mode_t  mode_q;
    logic       int_clk_q;
    logic       ext_q;
    logic       osc_tick;
    logic       int_rise;
    logic       ext_rise;
    logic       clk_tick;

    // The select pin is a strap, sampled by a clocked flop rather than under reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_sel_q <= 1'b0;
            mode_q    <= LBT_STATIC;
            ext_q     <= 1'b0;
        end else begin
            osc_sel_q <= oscillator_select_pin_i;
            mode_q    <= drive_mode_i;
            ext_q     <= ext_clk_i;
        end
    end

    lbt_tick_div #(.W(8), .MAX(LBT_OSC_MAX)) u_osc (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .en_i      (1'b1),
        .clr_i     (1'b0),
        .cnt_o     (),
        .tick_o    (osc_tick)
    );

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_clk_q <= 1'b0;
        end else if (osc_tick) begin
            int_clk_q <= ~int_clk_q;
        end
    end

    assign int_rise = osc_tick && !int_clk_q;
    assign ext_rise = ext_clk_i && !ext_q;
    assign clk_tick = osc_sel_q ? ext_rise : int_rise;

    // Oscillator keeps running even in external mode, but only drives the pin when selected
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clk_o    <= 1'b0;
            clk_oe_o <= 1'b0;
        end else begin
            clk_o    <= int_clk_q;
            clk_oe_o <= !osc_sel_q;
        end
    end

    // ==========================================================
    // Frame timing and cascade sync
    logic       sync_q;
    logic       sync_fall;
    logic [4:0] frm_cnt;
    logic       frame_tick;

    assign sync_fall = sync_q && !sync_i;

    lbt_tick_div #(.W(5), .MAX(LBT_FRAME_MAX)) u_frame (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .en_i      (clk_tick),
        .clr_i     (sync_fall),
        .cnt_o     (frm_cnt),
        .tick_o    (frame_tick)
    );

    // Each device pulls the open-drain sync low for one cycle at its frame start;
    // a falling edge from any device restarts every frame counter in the cascade
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_q    <= 1'b1;
            sync_o    <= 1'b0;
            sync_oe_o <= 1'b0;
            frame_o   <= 1'b0;
        end else begin
            sync_q    <= sync_i;
            sync_o    <= 1'b0;
            sync_oe_o <= frame_tick;
            frame_o   <= frame_tick;
        end
    end

    // ==========================================================
    // Row sequence within a frame
    logic [1:0] row_idx;
    logic [1:0] row_s;
    logic [1:0] row_2;
    logic [1:0] row_3;
    logic [1:0] row_4;

    assign row_s   = 2'h0;
    assign row_2   = (frm_cnt < LBT_SPLIT_2) ? 2'h0 : 2'h1;
    assign row_3   = (frm_cnt < LBT_SPLIT_3A) ? 2'h0 : ((frm_cnt < LBT_SPLIT_3B) ? 2'h1 : 2'h2);
    assign row_4   = (frm_cnt < LBT_SPLIT_4A) ? 2'h0 :
                     ((frm_cnt < LBT_SPLIT_4B) ? 2'h1 : ((frm_cnt < LBT_SPLIT_4C) ? 2'h2 : 2'h3));
    assign row_idx = (mode_q == LBT_STATIC) ? row_s :
                     ((mode_q == LBT_MUX2) ? row_2 : ((mode_q == LBT_MUX3) ? row_3 : row_4));

    // ==========================================================
    // Display RAM and byte packing
    logic [LBT_ROWS-1:0] ram_q [LBT_COLS];
    logic [5:0]          ptr_q;
    logic [5:0]          ptr_d;
    logic [5:0]          step;
    logic [5:0]          ptr_sum;
    logic [5:0]          wcol [8];
    logic [1:0]          wrow [8];
    logic                wr_ok [8];

    assign step    = (mode_q == LBT_STATIC) ? LBT_STEP_S :
                     ((mode_q == LBT_MUX2) ? LBT_STEP_2 : ((mode_q == LBT_MUX3) ? LBT_STEP_3 : LBT_STEP_4));
    assign ptr_sum = 6'(ptr_q + step);
    assign ptr_d   = wr_req_i.load ? wr_req_i.ptr :
                     (wr_req_i.store ? ((ptr_sum >= LBT_COLS_W) ? 6'(ptr_sum - LBT_COLS_W) : ptr_sum) : ptr_q);

    // Bit j counted from the MSB goes to column j/n and row j%n, n bits per column
    for (genvar j = 0; j < 8; j++) begin : g_place
        logic [2:0] n;
        assign n        = (mode_q == LBT_STATIC) ? 3'h1 :
                          ((mode_q == LBT_MUX2) ? 3'h2 : ((mode_q == LBT_MUX3) ? 3'h3 : 3'h4));
        assign wcol[j]  = 6'(ptr_q + 6'(3'(j) / n));
        assign wrow[j]  = 2'(3'(j) % n);
        assign wr_ok[j] = wr_req_i.store && (wcol[j] < LBT_COLS_W);
    end

    // Bits that run past the last column are dropped here; spill-over to the next
    // device is the job of the outside subaddress logic
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int c = 0; c < LBT_COLS; c++) begin
                ram_q[c] <= 4'h0;
            end
            ptr_q <= 6'h00;
        end else begin
            for (int j = 0; j < 8; j++) begin
                if (wr_ok[j]) begin
                    ram_q[wcol[j]][wrow[j]] <= wr_req_i.data[7-j];
                end
            end
            ptr_q <= ptr_d;
        end
    end

    // ==========================================================
    // Display register and outputs
    logic [39:0] row_bits;
    logic [39:0] disp_q;
    logic [3:0]  bp_pat;

    for (genvar c = 0; c < LBT_COLS; c++) begin : g_row
        assign row_bits[c] = ram_q[c][row_idx];
    end

    lbt_bp_map u_bp (
        .mode_i (mode_q),
        .row_i  (row_idx),
        .bp_o   (bp_pat)
    );

    // A set bit drives its segment active one cycle behind its backplane's active window
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            disp_q            <= 40'h00_0000_0000;
            segment_outputs_o <= 40'h00_0000_0000;
            backplane_out_o   <= 4'h0;
        end else begin
            disp_q            <= row_bits;
            segment_outputs_o <= disp_q;
            backplane_out_o   <= bp_pat;
        end
    end

    // ==========================================================
    // Checks
    logic [4:0] hc_q;
    logic       hv_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hc_q <= 5'h00;
            hv_q <= 1'b0;
        end else if (sync_fall || frame_tick) begin
            hc_q <= 5'h00;
            hv_q <= 1'b1;
        end else if (clk_tick) begin
            hc_q <= 5'(hc_q + 1'b1);
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_int_clk_out;
        !osc_sel_q ##1 !osc_sel_q |-> clk_oe_o && (clk_o == $past(int_clk_q));
    endproperty
    a_int_clk_out: assert property (p_int_clk_out) else $error("clock pin not driven in internal mode");

    property p_ext_clk_in;
        osc_sel_q |=> !clk_oe_o;
    endproperty
    a_ext_clk_in: assert property (p_ext_clk_in) else $error("clock pin driven in external mode");

    property p_frame_div;
        frame_tick && hv_q && !sync_fall |-> hc_q == 5'h17;
    endproperty
    a_frame_div: assert property (p_frame_div) else $error("frame tick not after 24 clock ticks");

    property p_sync_align;
        sync_fall |=> frm_cnt == 5'h00;
    endproperty
    a_sync_align: assert property (p_sync_align) else $error("frame counter not restarted by sync");

    property p_mux3_dup;
        mode_q == LBT_MUX3 ##1 mode_q == LBT_MUX3 |=> backplane_out_o[3] == backplane_out_o[1];
    endproperty
    a_mux3_dup: assert property (p_mux3_dup) else $error("backplane three differs from one");

    property p_mux2_dup;
        mode_q == LBT_MUX2 ##1 mode_q == LBT_MUX2 |=> backplane_out_o[3:2] == backplane_out_o[1:0]
                                                      && ^backplane_out_o[1:0];
    endproperty
    a_mux2_dup: assert property (p_mux2_dup) else $error("two-backplane duplication broken");

    property p_static_bp;
        mode_q == LBT_STATIC ##1 mode_q == LBT_STATIC |=> backplane_out_o == 4'hF;
    endproperty
    a_static_bp: assert property (p_static_bp) else $error("static backplanes not identical");

    property p_ptr_step;
        wr_req_i.store && !wr_req_i.load && ptr_q < 6'h20
            |=> ptr_q == 6'($past(ptr_q) + (($past(mode_q) == LBT_STATIC) ? LBT_STEP_S :
                (($past(mode_q) == LBT_MUX2) ? LBT_STEP_2 :
                (($past(mode_q) == LBT_MUX3) ? LBT_STEP_3 : LBT_STEP_4))));
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("write pointer step wrong");

    property p_static_pack;
        wr_req_i.store && mode_q == LBT_STATIC && ptr_q < 6'h20
            |=> ram_q[$past(ptr_q)][0] == $past(wr_req_i.data[7]) && ram_q[6'($past(ptr_q) + 6'h07)][0] == $past(wr_req_i.data[0]);
    endproperty
    a_static_pack: assert property (p_static_pack) else $error("static packing wrong");

    property p_mux3_keep;
        wr_req_i.store && mode_q == LBT_MUX3 && ptr_q < 6'h20
            |=> ram_q[6'($past(ptr_q) + 6'h02)][2] == $past(ram_q[6'(ptr_q + 6'h02)][2]);
    endproperty
    a_mux3_keep: assert property (p_mux3_keep) else $error("leftover row-two bit modified");

    property p_seg_follow;
        !wr_req_i.store ##1 !wr_req_i.store && $stable(row_idx) |=> segment_outputs_o == $past(row_bits, 2);
    endproperty
    a_seg_follow: assert property (p_seg_follow) else $error("segments not following active RAM row");

endmodule // lbt_top
